/* File: hdl/timer_cmp_params.svh */
// Constants of the compare, single-pulse and PWM timer block.
// Assumes inclusion by bare name from the design modules.
`ifndef TIMER_CMP_PARAMS_SVH
`define TIMER_CMP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TMR_OFS_CTRL_ONE     4'h0
`define TMR_OFS_CTRL_TWO     4'h1
`define TMR_OFS_FLAGS        4'h2
`define TMR_OFS_CMP1_HIGH    4'h3
`define TMR_OFS_CMP1_LOW     4'h4
`define TMR_OFS_CMP2_HIGH    4'h5
`define TMR_OFS_CMP2_LOW     4'h6
`define TMR_OFS_CAP1_HIGH    4'h7
`define TMR_OFS_CAP1_LOW     4'h8
`define TMR_OFS_CAP2_HIGH    4'h9
`define TMR_OFS_CAP2_LOW     4'ha
`define TMR_OFS_COUNT_HIGH   4'hb
`define TMR_OFS_COUNT_LOW    4'hc

// ----------------------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------------------
`define TMR_FLG_CAP_ONE      7
`define TMR_FLG_MATCH_ONE    6
`define TMR_FLG_CAP_TWO      4
`define TMR_FLG_MATCH_TWO    3

// ----------------------------------------------------------------------------
// Reset and reload values
// ----------------------------------------------------------------------------
`define TMR_CMP_RESET        16'h8000
`define TMR_CNT_RESTART      16'hfffc
`define TMR_CAP_PULSE_VALUE  16'hfffd
`define TMR_CTRL_RESET       8'h00

// ----------------------------------------------------------------------------
// Prescaler terminal masks for divide by 2, 4 and 8
// ----------------------------------------------------------------------------
`define TMR_DIV2_MASK        3'h1
`define TMR_DIV4_MASK        3'h3
`define TMR_DIV8_MASK        3'h7

`endif

/* File: hdl/timer_cmp_pkg.sv */
// Types of the compare, single-pulse and PWM timer block.
// Assumes the constants header is on the include path.
package timer_cmp_pkg;

	// ------------------------------------------------------------------------
	// Tick source and control layouts
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		TICK_DIV2 = 2'b00,
		TICK_DIV4 = 2'b01,
		TICK_DIV8 = 2'b10,
		TICK_EXT  = 2'b11
	} tick_sel_t;

	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_level_two;
		logic force_level_one;
		logic level_after_match_two;
		logic capture_edge_one;
		logic level_after_match_one;
	} ctrl_one_t;

	typedef struct packed {
		logic      pin_one_output_enable;
		logic      pin_two_output_enable;
		logic      single_pulse_select;
		logic      pwm_select;
		tick_sel_t tick_source_select;
		logic      capture_edge_two;
		logic      ext_edge_rising;
	} ctrl_two_t;

	// ------------------------------------------------------------------------
	// Register port request
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

/* File: hdl/tick_source.sv */
// Timer tick generator: CPU clock prescaler or synchronised external clock.
// Assumes the external pin is asynchronous and at most a quarter of the clock rate.
`include "timer_cmp_params.svh"

module tick_source (
	input  wire logic                     i_ref_clk, // CPU clock
	input  wire logic                     i_srst,    // Synchronous reset
	input  wire timer_cmp_pkg::tick_sel_t i_sel,     // Tick source select
	input  wire logic                     i_rising,  // External active edge is rising
	input  wire logic                     i_ext_pin, // External tick pin
	output logic                          o_tick     // One-cycle tick pulse
);

	typedef struct packed {
		logic [2:0] div;
		logic       s1;
		logic       s2;
		logic       prev;
		logic       tick;
	} tick_state_t;

	tick_state_t q;
	tick_state_t d;

	always_comb begin
		d      = q;
		d.div  = q.div + 3'h1;
		d.s1   = i_ext_pin;
		d.s2   = q.s1;
		d.prev = q.s2;
		unique case (i_sel)
			timer_cmp_pkg::TICK_DIV2: d.tick = ((q.div & `TMR_DIV2_MASK) == `TMR_DIV2_MASK);
			timer_cmp_pkg::TICK_DIV4: d.tick = ((q.div & `TMR_DIV4_MASK) == `TMR_DIV4_MASK);
			timer_cmp_pkg::TICK_DIV8: d.tick = ((q.div & `TMR_DIV8_MASK) == `TMR_DIV8_MASK);
			timer_cmp_pkg::TICK_EXT:  d.tick = i_rising ? (q.s2 & ~q.prev) : (~q.s2 & q.prev);
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_tick = q.tick;

endmodule

/* File: hdl/compare_channel.sv */
// One compare channel: WIDTH-bit value register written a byte at a time, write inhibit and match detect.
// Assumes the probe value is already aligned to the selected prescale.
`include "timer_cmp_params.svh"

module compare_channel #(
	parameter int WIDTH = 16
) (
	input  wire logic             i_ref_clk,  // CPU clock
	input  wire logic             i_srst,     // Synchronous reset
	input  wire logic             i_wr_high,  // Write strobe, high byte
	input  wire logic             i_wr_low,   // Write strobe, low byte
	input  wire logic [7:0]       i_data,     // Write data
	input  wire logic             i_tick,     // Timer tick
	input  wire logic [WIDTH-1:0] i_probe,    // Count value to compare with
	output logic [WIDTH-1:0]      o_value,    // Stored compare value
	output logic                  o_match     // One-cycle match pulse
);

	if (WIDTH <= 8 || WIDTH > 16) begin : g_bad_width
		$error("compare_channel WIDTH must be 9 to 16");
	end

	typedef struct packed {
		logic [WIDTH-1:0] value;
		logic             inhibit;
	} cmp_state_t;

	cmp_state_t q;
	cmp_state_t d;

	// Hardware never writes the value; only the two byte strobes do.
	always_comb begin
		d = q;
		if (i_wr_high) begin
			d.value[WIDTH-1:8] = i_data[WIDTH-9:0];
			d.inhibit          = 1'b1;
		end
		if (i_wr_low) begin
			d.value[7:0] = i_data;
			d.inhibit    = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			q.value   <= WIDTH'(`TMR_CMP_RESET);
			q.inhibit <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign o_value = q.value;
	assign o_match = i_tick & ~q.inhibit & (i_probe == q.value);

endmodule

/* File: hdl/timer_compare_pulse_pwm.sv */
// Compare, single-pulse and PWM logic of a 16-bit timer, with its register port.
// Assumes a one-clock register master and asynchronous trigger and tick pins.
`include "timer_cmp_params.svh"

module timer_compare_pulse_pwm (
	input  wire logic                    i_ref_clk,             // CPU clock, 40 MHz
	input  wire logic                    i_srst,                // Synchronous reset, active high
	input  wire timer_cmp_pkg::reg_req_t i_bus,                 // Register request
	output logic [7:0]                   o_rdata,               // Read data, cycle after the read
	input  wire logic                    i_irq_mask,            // Processor interrupt mask bit
	input  wire logic                    i_external_tick_pin,   // External tick pin
	input  wire logic                    i_trigger_pin_one,     // Trigger pin one
	input  wire logic                    i_trigger_pin_two,     // Trigger pin two
	output logic                         o_waveform_pin_one,    // Waveform pin one level
	output logic                         o_waveform_pin_one_oe, // Waveform pin one drive enable
	output logic                         o_waveform_pin_two,    // Waveform pin two level
	output logic                         o_waveform_pin_two_oe, // Waveform pin two drive enable
	output logic                         o_timer_irq            // Timer interrupt request
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		timer_cmp_pkg::ctrl_one_t c1;
		timer_cmp_pkg::ctrl_two_t c2;
		logic [15:0]              cnt;
		logic [15:0]              cap1;
		logic [15:0]              cap2;
		logic                     mf1;
		logic                     mf2;
		logic                     cf1;
		logic                     cf2;
		logic                     am1;
		logic                     am2;
		logic                     ac1;
		logic                     ac2;
		logic                     pin1;
		logic                     pin2;
		logic                     t1_s1;
		logic                     t1_s2;
		logic                     t1_prev;
		logic                     t2_s1;
		logic                     t2_s2;
		logic                     t2_prev;
		logic [7:0]               rdata;
		logic                     restart_pend;
	} top_state_t;

	top_state_t q;
	top_state_t d;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Two-step flag clear with the set taking priority; returns {flag, arm}.
	function automatic logic [1:0] flag_step(
		input logic flag,
		input logic arm,
		input logic status_rd,
		input logic low_access,
		input logic set
	);
		logic f;
		logic a;
		f = flag;
		a = arm;
		if (status_rd && flag) begin
			a = 1'b1;
		end
		if (low_access && arm) begin
			f = 1'b0;
			a = 1'b0;
		end
		if (set) begin
			f = 1'b1;
		end
		return {f, a};
	endfunction

	function automatic logic edge_seen(
		input logic rising,
		input logic now,
		input logic prev
	);
		return rising ? (now & ~prev) : (~now & prev);
	endfunction

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	logic        pwm_on;
	logic        pulse_on;
	logic        plain_on;
	logic        div2_on;
	logic        tick;
	logic        match1;
	logic        match2;
	logic        trig1_edge;
	logic        trig2_edge;
	logic [15:0] cnt_inc;
	logic [15:0] probe;
	logic [15:0] cmp1_value;
	logic [15:0] cmp2_value;
	logic        wr_cmp1_high;
	logic        wr_cmp1_low;
	logic        wr_cmp2_high;
	logic        wr_cmp2_low;
	logic        status_rd;

	assign pwm_on     = q.c2.pwm_select;
	assign pulse_on   = q.c2.single_pulse_select & ~q.c2.pwm_select;
	assign plain_on   = ~q.c2.single_pulse_select & ~q.c2.pwm_select;
	assign div2_on    = (q.c2.tick_source_select == timer_cmp_pkg::TICK_DIV2);
	assign cnt_inc    = q.cnt + 16'h0001;
	assign trig1_edge = edge_seen(q.c1.capture_edge_one, q.t1_s2, q.t1_prev) & ~pwm_on;
	assign trig2_edge = edge_seen(q.c2.capture_edge_two, q.t2_s2, q.t2_prev);

	// At divide by 2 the match lands as the counter reaches the value; at slower
	// rates it lands one count later, as the counter leaves it.
	assign probe = div2_on ? cnt_inc : q.cnt;

	assign wr_cmp1_high = i_bus.wr && (i_bus.addr == `TMR_OFS_CMP1_HIGH);
	assign wr_cmp1_low  = i_bus.wr && (i_bus.addr == `TMR_OFS_CMP1_LOW);
	assign wr_cmp2_high = i_bus.wr && (i_bus.addr == `TMR_OFS_CMP2_HIGH);
	assign wr_cmp2_low  = i_bus.wr && (i_bus.addr == `TMR_OFS_CMP2_LOW);
	assign status_rd    = i_bus.rd && (i_bus.addr == `TMR_OFS_FLAGS);

	// ------------------------------------------------------------------------
	// Tick source and compare channels
	// ------------------------------------------------------------------------
	tick_source u_tick (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_sel     (q.c2.tick_source_select),
		.i_rising  (q.c2.ext_edge_rising),
		.i_ext_pin (i_external_tick_pin),
		.o_tick    (tick)
	);

	compare_channel #(
		.WIDTH (16)
	) u_cmp1 (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_wr_high (wr_cmp1_high),
		.i_wr_low  (wr_cmp1_low),
		.i_data    (i_bus.wdata),
		.i_tick    (tick),
		.i_probe   (probe),
		.o_value   (cmp1_value),
		.o_match   (match1)
	);

	compare_channel #(
		.WIDTH (16)
	) u_cmp2 (
		.i_ref_clk (i_ref_clk),
		.i_srst    (i_srst),
		.i_wr_high (wr_cmp2_high),
		.i_wr_low  (wr_cmp2_low),
		.i_data    (i_bus.wdata),
		.i_tick    (tick),
		.i_probe   (probe),
		.o_value   (cmp2_value),
		.o_match   (match2)
	);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	logic                     set_m1;
	logic                     set_m2;
	logic                     set_c1;
	logic                     set_c2;
	logic                     acc_cmp1_low;
	logic                     acc_cmp2_low;
	logic                     acc_cap1_low;
	logic                     acc_cap2_low;
	timer_cmp_pkg::ctrl_one_t new_c1;

	assign set_m1 = match1 & plain_on;
	assign set_m2 = match2 & ~pwm_on;
	assign set_c1 = trig1_edge | (pwm_on & match2);
	assign set_c2 = trig2_edge;
	assign new_c1 = timer_cmp_pkg::ctrl_one_t'(i_bus.wdata);

	assign acc_cmp1_low = (i_bus.rd | i_bus.wr) && (i_bus.addr == `TMR_OFS_CMP1_LOW);
	assign acc_cmp2_low = (i_bus.rd | i_bus.wr) && (i_bus.addr == `TMR_OFS_CMP2_LOW);
	assign acc_cap1_low = (i_bus.rd | i_bus.wr) && (i_bus.addr == `TMR_OFS_CAP1_LOW);
	assign acc_cap2_low = (i_bus.rd | i_bus.wr) && (i_bus.addr == `TMR_OFS_CAP2_LOW);

	always_comb begin
		d = q;

		// Trigger pins: the first stage feeds only the second.
		d.t1_s1   = i_trigger_pin_one;
		d.t1_s2   = q.t1_s1;
		d.t1_prev = q.t1_s2;
		d.t2_s1   = i_trigger_pin_two;
		d.t2_s2   = q.t2_s1;
		d.t2_prev = q.t2_s2;

		// Counter; a restart overrides the tick increment.
		if (tick) begin
			d.cnt = cnt_inc;
		end
		if (pulse_on && trig1_edge) begin
			d.cnt = `TMR_CNT_RESTART;
		end
		// At divide by 2 the period match lands as the counter reaches the value, so it restarts a tick later.
		d.restart_pend = (q.restart_pend & pwm_on & ~tick) | (pwm_on & match2 & div2_on);
		if ((pwm_on && match2 && !div2_on) || (tick && q.restart_pend && pwm_on)) begin
			d.cnt = `TMR_CNT_RESTART;
		end

		// Capture registers.
		if (trig1_edge) begin
			d.cap1 = pulse_on ? `TMR_CAP_PULSE_VALUE : q.cnt;
		end
		if (trig2_edge) begin
			d.cap2 = q.cnt;
		end

		// Flags.
		{d.mf1, d.am1} = flag_step(q.mf1, q.am1, status_rd, acc_cmp1_low, set_m1);
		{d.mf2, d.am2} = flag_step(q.mf2, q.am2, status_rd, acc_cmp2_low, set_m2);
		{d.cf1, d.ac1} = flag_step(q.cf1, q.ac1, status_rd, acc_cap1_low, set_c1);
		{d.cf2, d.ac2} = flag_step(q.cf2, q.ac2, status_rd, acc_cap2_low, set_c2);

		// Waveform latches.
		if (plain_on) begin
			if (match1 && q.c2.pin_one_output_enable) begin
				d.pin1 = q.c1.level_after_match_one;
			end
			if (match2 && q.c2.pin_two_output_enable) begin
				d.pin2 = q.c1.level_after_match_two;
			end
		end else if (pulse_on) begin
			if (match1) begin
				d.pin1 = q.c1.level_after_match_one;
			end
			if (trig1_edge) begin
				d.pin1 = q.c1.level_after_match_two;
			end
		end else begin
			if (match1) begin
				d.pin1 = q.c1.level_after_match_one;
			end
			if (match2) begin
				d.pin1 = q.c1.level_after_match_two;
			end
		end

		// Control writes; in plain mode with the pin enabled a force takes effect at once and touches no flag.
		if (i_bus.wr && (i_bus.addr == `TMR_OFS_CTRL_ONE)) begin
			d.c1 = new_c1;
			if (plain_on) begin
				if (new_c1.force_level_one && q.c2.pin_one_output_enable) begin
					d.pin1 = new_c1.level_after_match_one;
				end
				if (new_c1.force_level_two && q.c2.pin_two_output_enable) begin
					d.pin2 = new_c1.level_after_match_two;
				end
			end
		end
		if (i_bus.wr && (i_bus.addr == `TMR_OFS_CTRL_TWO)) begin
			d.c2 = timer_cmp_pkg::ctrl_two_t'(i_bus.wdata);
		end

		// Read data stand for exactly the cycle after the strobe.
		d.rdata = 8'h00;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				`TMR_OFS_CTRL_ONE:   d.rdata = q.c1;
				`TMR_OFS_CTRL_TWO:   d.rdata = q.c2;
				`TMR_OFS_FLAGS: begin
					d.rdata[`TMR_FLG_CAP_ONE]   = q.cf1;
					d.rdata[`TMR_FLG_MATCH_ONE] = q.mf1;
					d.rdata[`TMR_FLG_CAP_TWO]   = q.cf2;
					d.rdata[`TMR_FLG_MATCH_TWO] = q.mf2;
				end
				`TMR_OFS_CMP1_HIGH:  d.rdata = cmp1_value[15:8];
				`TMR_OFS_CMP1_LOW:   d.rdata = cmp1_value[7:0];
				`TMR_OFS_CMP2_HIGH:  d.rdata = cmp2_value[15:8];
				`TMR_OFS_CMP2_LOW:   d.rdata = cmp2_value[7:0];
				`TMR_OFS_CAP1_HIGH:  d.rdata = q.cap1[15:8];
				`TMR_OFS_CAP1_LOW:   d.rdata = q.cap1[7:0];
				`TMR_OFS_CAP2_HIGH:  d.rdata = q.cap2[15:8];
				`TMR_OFS_CAP2_LOW:   d.rdata = q.cap2[7:0];
				`TMR_OFS_COUNT_HIGH: d.rdata = q.cnt[15:8];
				`TMR_OFS_COUNT_LOW:  d.rdata = q.cnt[7:0];
				default:             d.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			q      <= '0;
			q.c1   <= timer_cmp_pkg::ctrl_one_t'(`TMR_CTRL_RESET);
			q.c2   <= timer_cmp_pkg::ctrl_two_t'(`TMR_CTRL_RESET);
			q.cnt  <= `TMR_CNT_RESTART;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign o_rdata               = q.rdata;
	assign o_waveform_pin_one    = q.pin1;
	assign o_waveform_pin_one_oe = q.c2.pin_one_output_enable;
	assign o_waveform_pin_two    = q.pin2;
	assign o_waveform_pin_two_oe = q.c2.pin_two_output_enable;

	// Compare flags cannot be set in PWM, so that term stays quiet there.
	assign o_timer_irq = ~i_irq_mask &
		((q.c1.compare_irq_enable & (q.mf1 | q.mf2)) |
		 (q.c1.capture_irq_enable & (q.cf1 | q.cf2)));

endmodule

/* File: testbench/timer_cmp_checker.sv */
// Port checker for the compare, single-pulse and PWM timer block.
// Assumes it is bound to the top module and sees only its ports.
module timer_cmp_checker (
	input wire logic                    i_ref_clk,             // CPU clock
	input wire logic                    i_srst,                // Synchronous reset
	input wire timer_cmp_pkg::reg_req_t i_bus,                 // Register request
	input wire logic [7:0]              o_rdata,               // Read data
	input wire logic                    i_irq_mask,            // Interrupt mask
	input wire logic                    i_external_tick_pin,   // External tick pin
	input wire logic                    i_trigger_pin_one,     // Trigger pin one
	input wire logic                    i_trigger_pin_two,     // Trigger pin two
	input wire logic                    o_waveform_pin_one,    // Waveform pin one
	input wire logic                    o_waveform_pin_one_oe, // Pin one enable
	input wire logic                    o_waveform_pin_two,    // Waveform pin two
	input wire logic                    o_waveform_pin_two_oe, // Pin two enable
	input wire logic                    o_timer_irq            // Interrupt request
);
	logic [7:0] ctl1_q;
	logic [7:0] ctl2_q;
	logic       force_one;

	// ------------------------------------------------------------------------
	// Shadow of the control registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ctl1_q <= 8'h00;
			ctl2_q <= 8'h00;
		end else if (i_bus.wr && i_bus.addr == 4'h0) begin
			ctl1_q <= i_bus.wdata;
		end else if (i_bus.wr && i_bus.addr == 4'h1) begin
			ctl2_q <= i_bus.wdata;
		end
	end
	// Force only counts in plain mode with the pin enabled, using the mode before the write.
	assign force_one = i_bus.wr && i_bus.addr == 4'h0 && i_bus.wdata[3] && ctl2_q[7] && ctl2_q[5:4] == 2'b00;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	AST_PIN_RESET: assert property (@(posedge i_ref_clk)
		$past(i_srst) |-> !o_waveform_pin_one && !o_waveform_pin_two && !o_waveform_pin_one_oe)
		else $error("pin latch not low in reset");
	AST_IRQ_MASK: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_irq_mask |-> !o_timer_irq) else $error("irq raised while masked");
	AST_IRQ_OFF: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		ctl1_q[7:6] == 2'b00 |-> !o_timer_irq) else $error("irq raised with enables clear");
	AST_RD_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("read data outside read cycle");
	AST_RD_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_bus.rd && i_bus.addr > 4'hc |=> o_rdata == 8'h00) else $error("unmapped read not zero");
	AST_FLAG_RSV: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_bus.rd && i_bus.addr == 4'h2 |=> o_rdata[5] == 1'b0 && o_rdata[2:0] == 3'h0)
		else $error("reserved flag bits set");
	AST_OE_FOLLOWS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_bus.wr && i_bus.addr == 4'h1 |=> o_waveform_pin_one_oe == $past(i_bus.wdata[7])
		&& o_waveform_pin_two_oe == $past(i_bus.wdata[6])) else $error("pin enable wrong");
	AST_OE_STABLE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		!$past(i_bus.wr) |-> $stable(o_waveform_pin_one_oe) && $stable(o_waveform_pin_two_oe))
		else $error("pin enable moved without write");
	AST_FORCE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		force_one |=> o_waveform_pin_one == $past(i_bus.wdata[0])) else $error("force level not copied");
endmodule

bind timer_compare_pulse_pwm timer_cmp_checker u_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_bus(i_bus),
	.o_rdata(o_rdata), .i_irq_mask(i_irq_mask), .i_external_tick_pin(i_external_tick_pin),
	.i_trigger_pin_one(i_trigger_pin_one), .i_trigger_pin_two(i_trigger_pin_two),
	.o_waveform_pin_one(o_waveform_pin_one), .o_waveform_pin_one_oe(o_waveform_pin_one_oe),
	.o_waveform_pin_two(o_waveform_pin_two), .o_waveform_pin_two_oe(o_waveform_pin_two_oe),
	.o_timer_irq(o_timer_irq));

/* File: testbench/trig_partner.sv */
// Model of the circuitry on the trigger pins and the external tick pin.
// Assumes the bench raises i_fire to request trigger edges on pin one.
module trig_partner (
	input  wire logic i_ref_clk,  // CPU clock
	input  wire logic i_fire,     // Request trigger edges on pin one
	output logic      o_trig_one, // Trigger pin one
	output logic      o_trig_two, // Trigger pin two
	output logic      o_ext       // External tick pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_q = 4'h0;
	logic [7:0] div_q = 8'h00;

	always @(posedge i_ref_clk) begin
		div_q <= div_q + 8'h01;
		hold_q <= (i_fire && hold_q == 4'h0) ? 4'hc : hold_q - {3'b000, hold_q != 4'h0};
	end
	// An eight-clock tick period keeps active edges over four clocks apart.
	assign o_ext = div_q[2];
	assign o_trig_one = hold_q != 4'h0;
	assign o_trig_two = div_q[7];
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the compare, single-pulse and PWM timer block.
// Assumes the register map and bit layouts given in the block's hand-over.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk = 1'b0;
	logic                    srst = 1'b1;
	timer_cmp_pkg::reg_req_t bus = '0;
	logic                    mask = 1'b0;
	logic                    fire = 1'b0;
	logic [7:0]              rdata;
	logic                    ext, trg1, trg2, pin1, oe1, pin2, oe2, irq;
	int                      n_fail = 0;
	int                      comparisons = 0;

	initial begin
		forever #12.5 clk = ~clk;
	end

	trig_partner u_far (.i_ref_clk(clk), .i_fire(fire), .o_trig_one(trg1), .o_trig_two(trg2), .o_ext(ext));

	timer_compare_pulse_pwm u_dut (.i_ref_clk(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata),
		.i_irq_mask(mask), .i_external_tick_pin(ext), .i_trigger_pin_one(trg1), .i_trigger_pin_two(trg2),
		.o_waveform_pin_one(pin1), .o_waveform_pin_one_oe(oe1), .o_waveform_pin_two(pin2),
		.o_waveform_pin_two_oe(oe2), .o_timer_irq(irq));

	// ------------------------------------------------------------------------
	// Bus and check helpers
	// ------------------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd8(a, v[15:8]);
		rd8(a + 4'h1, v[7:0]);
	endtask
	task automatic do_reset;
		srst <= 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
	endtask
	task automatic wait_pin(input logic lv, output int n);
		n = 0;
		while (pin1 !== lv && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			n_fail++;
		end
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] v;
		rd16(4'h3, v);
		chk("cmp1 reset", v, 16'h8000);
		rd16(4'h5, v);
		chk("cmp2 reset", v, 16'h8000);
		wr(4'h5, 8'h12);
		wr(4'h6, 8'h34);
		rd16(4'h5, v);
		chk("cmp2 rw", v, 16'h1234);
		rd8(4'hf, v[7:0]);
		chk("unmapped", v[7:0], 8'h00);
		$display("test regs done");
	endtask
	task automatic t_match(input logic [1:0] sel);
		logic [7:0] d;
		int         n;
		do_reset();
		wr(4'h0, 8'h41);
		wr(4'h1, {4'h8, sel, 2'b01});
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h30);
		n = 0;
		// Count low is read every cycle so the value seen aligns with the pin edge.
		while (pin1 !== 1'b1 && n < 3000) begin
			@(posedge clk);
			bus <= '{4'hc, 8'h00, 1'b0, 1'b1};
			n++;
		end
		@(posedge clk);
		bus <= '0;
		chk("match count", rdata, (sel == 2'b00) ? 8'h30 : 8'h31);
		rd8(4'h4, d);
		rd8(4'h2, d);
		chk("flag held", d[6], 1'b1);
		chk("irq", irq, 1'b1);
		mask <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		chk("irq masked", irq, 1'b0);
		mask <= 1'b0;
		rd8(4'h4, d);
		rd8(4'h2, d);
		chk("flag cleared", d[6], 1'b0);
		$display("test match done");
	endtask
	task automatic t_suspend;
		logic [7:0] d;
		do_reset();
		wr(4'h0, 8'h41);
		wr(4'h3, 8'h00);
		repeat (100) @(posedge clk);
		rd8(4'h2, d);
		chk("suspended", d[6], 1'b0);
		wr(4'h4, 8'h80);
		repeat (200) @(posedge clk);
		rd8(4'h2, d);
		chk("resumed", d[6], 1'b1);
		chk("pin free", oe1, 1'b0);
		chk("pin held", pin1, 1'b0);
		$display("test suspend done");
	endtask
	task automatic t_force;
		logic [7:0] d;
		do_reset();
		wr(4'h1, 8'hc0);
		wr(4'h0, 8'h5d);
		@(posedge clk);
		chk("forced", pin1, 1'b1);
		chk("forced two", pin2 & oe2, 1'b1);
		rd8(4'h2, d);
		chk("no flag", d, 8'h00);
		chk("no irq", irq, 1'b0);
		wr(4'h1, 8'hb0);
		wr(4'h0, 8'h08);
		@(posedge clk);
		chk("force ignored", pin1, 1'b1);
		$display("test force done");
	endtask
	task automatic t_pulse;
		logic [15:0] v;
		int          n;
		do_reset();
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h20);
		wr(4'h0, 8'h46);
		wr(4'h1, 8'ha0);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wait_pin(1'b1, n);
		chk("pulse start", pin1, 1'b1);
		wait_pin(1'b0, n);
		chk("pulse end", pin1, 1'b0);
		rd16(4'h7, v);
		chk("pulse capture", v, 16'hfffd);
		rd8(4'h2, v[7:0]);
		chk("pulse flags", {v[7], v[6]}, 2'b10);
		$display("test pulse done");
	endtask
	task automatic t_pwm;
		logic [7:0] d;
		int         hi;
		int         lo;
		do_reset();
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h10);
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h20);
		wr(4'h0, 8'hc4);
		wr(4'h1, 8'hb0);
		wait_pin(1'b1, hi);
		fire <= 1'b1;
		wait_pin(1'b0, hi);
		wait_pin(1'b1, lo);
		fire <= 1'b0;
		chk("pwm high", hi[15:0], 16'd42);
		chk("pwm period", hi[15:0] + lo[15:0], 16'd74);
		rd8(4'h2, d);
		chk("pwm flags", {d[7], d[6], d[3]}, 3'b100);
		chk("pwm irq", irq, 1'b1);
		$display("test pwm done");
	endtask

	// ------------------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------------------
	task automatic end_sim;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		t_regs();
		for (int s = 0; s < 4; s++) begin
			t_match(s[1:0]);
		end
		t_suspend();
		t_force();
		t_pulse();
		t_pwm();
		end_sim();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		end_sim();
	end
endmodule
